// File: inc/dfba_pkg.sv
// shared constants and types of the data flash block access gateway
package dfba_pkg;

	// command space addresses
	localparam logic [7:0] CMD_SUBCLASS = 8'h3E;
	localparam logic [7:0] CMD_BLKIDX   = 8'h3F;
	localparam logic [7:0] CMD_WIN_BASE = 8'h40;
	localparam logic [7:0] CMD_WIN_LAST = 8'h5F;
	localparam logic [7:0] CMD_CSUM     = 8'h60;
	localparam logic [7:0] CMD_ACCSEL   = 8'h61;

	// block access select values
	localparam logic [7:0] ACC_GENERAL = 8'h00;
	localparam logic [7:0] ACC_MFR     = 8'h01;

	// flash geometry: byte address = {subclass, block, offset}
	localparam int SC_W  = 7;
	localparam int BLK_W = 2;
	localparam int OFF_W = 5;
	localparam int BA_W  = SC_W + BLK_W;
	localparam int FA_W  = BA_W + OFF_W;
	localparam int BLK_BYTES = 32;

	// manufacturer blocks A, B, C are blocks 0..2 of this subclass
	localparam logic [SC_W-1:0]  MFR_SC    = 7'h3A;
	localparam logic [BLK_W-1:0] MFR_A_BLK = 2'h0;
	// subclasses from here up are private; key words live in the first one
	localparam logic [SC_W-1:0]  PRIV_SC_FIRST = 7'h70;
	localparam logic [BA_W-1:0]  KEY_BLK  = 9'h1C0;
	localparam logic [FA_W-1:0]  KEY_ADDR = 14'h3800;
	localparam logic [7:0]       FLASH_ERASED = 8'hFF;

	// checksum complement base
	localparam logic [7:0] CSUM_BASE = 8'hFF;

	// control word subcommands
	localparam logic [15:0] SUB_SEAL      = 16'h0020;
	localparam logic [15:0] SUB_BOOT      = 16'h0F00;
	localparam logic [15:0] SUB_EXIT_BOOT = 16'h0F01;

	// control state word bit positions
	localparam int ST_SEALED_BIT = 13;
	localparam int ST_FAS_BIT    = 14;
	localparam int ST_BOOT_BIT   = 15;

	typedef enum logic [1:0] {
		SEC_LOCKED, SEC_UNLOCKED, SEC_PRIV, SEC_BOOT
	} dfba_sec_t;

	typedef enum logic [1:0] {XF_IDLE, XF_LOAD, XF_COMMIT} dfba_xfer_t;

	// key word as written on the control port is the stored word byte-swapped
	function automatic logic [15:0] swap16(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction

	function automatic logic [7:0] byte_sum(input logic [31:0][7:0] b);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 32; i++) begin
			s = s + b[i];
		end
		return s;
	endfunction

endpackage

// File: rtl/dfba_flash.sv
// non-volatile byte array with a block port and a key word tap
`timescale 1ns/1ps
`default_nettype none
module dfba_flash
	import dfba_pkg::*;
#(
	parameter int AW = FA_W
) (
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata,
	// stored key bytes, in address order
	output logic      [63:0]   key_bytes
);

	logic [7:0] mem [2**AW];

	// models an erased part; contents are never touched by reset
	initial begin
		for (int i = 0; i < 2**AW; i++) begin
			mem[i] = FLASH_ERASED;
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata; // RULE9
		end
	end

	assign rdata = mem[raddr];

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			key_bytes[i*8 +: 8] = mem[KEY_ADDR + AW'(i)];
		end
	end

endmodule
`default_nettype wire

// File: rtl/dfba_keyseq.sv
// security state machine driven by control port key sequences
`timescale 1ns/1ps
`default_nettype none
module dfba_keyseq
	import dfba_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control word port
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	// stored keys: unlock 0/1 then privileged 0/1, two bytes each
	input  wire logic [63:0] key_bytes,
	// state
	output dfba_sec_t        mode
);

	dfba_sec_t  mode_q;
	dfba_sec_t  mode_d;
	logic       arm_unl_q;
	logic       arm_fa_q;
	logic       arm_unl_d;
	logic       arm_fa_d;
	logic [15:0] unl0, unl1, fa0, fa1;

	// stored word reads back as {low address byte, high address byte}
	assign unl0 = swap16({key_bytes[7:0],   key_bytes[15:8]});   // RULE22
	assign unl1 = swap16({key_bytes[23:16], key_bytes[31:24]});  // RULE22
	assign fa0  = swap16({key_bytes[39:32], key_bytes[47:40]});  // RULE22
	assign fa1  = swap16({key_bytes[55:48], key_bytes[63:56]});  // RULE22

	// any write re-decides the armed flags, so a stray word aborts
	assign arm_unl_d = wr ? (wdata == unl0 && mode_q == SEC_LOCKED)
		: arm_unl_q; // RULE17
	assign arm_fa_d = wr ? (wdata == fa0 && mode_q == SEC_UNLOCKED)
		: arm_fa_q; // RULE17

	always_comb begin
		mode_d = mode_q;
		if (wr) begin
			case (mode_q)
			SEC_LOCKED: begin
				if (arm_unl_q && wdata == unl1) begin
					mode_d = SEC_UNLOCKED; // RULE19
				end
			end
			SEC_UNLOCKED: begin
				if (arm_fa_q && wdata == fa1) begin
					mode_d = SEC_PRIV; // RULE20
				end else if (wdata == SUB_SEAL) begin
					mode_d = SEC_LOCKED;
				end
			end
			SEC_PRIV: begin
				if (wdata == SUB_BOOT) begin
					mode_d = SEC_BOOT; // RULE16
				end else if (wdata == SUB_SEAL) begin
					mode_d = SEC_LOCKED;
				end
			end
			SEC_BOOT: begin
				if (wdata == SUB_EXIT_BOOT) begin
					mode_d = SEC_LOCKED;
				end
			end
			default: mode_d = SEC_LOCKED;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q    <= SEC_LOCKED;
			arm_unl_q <= 1'b0;
			arm_fa_q  <= 1'b0;
		end else begin
			mode_q    <= mode_d;
			arm_unl_q <= arm_unl_d;
			arm_fa_q  <= arm_fa_d;
		end
	end

	assign mode = mode_q;

	property p_unlock;
		@(posedge clk) disable iff (rst)
		(mode_q == SEC_LOCKED && arm_unl_q && wr && wdata == unl1)
			|=> (mode_q == SEC_UNLOCKED);
	endproperty
	a_unlock: assert property (p_unlock) // RULE19
		else $error("unlock pair did not unlock");

	property p_priv;
		@(posedge clk) disable iff (rst)
		(mode_q == SEC_UNLOCKED && arm_fa_q && wr && wdata == fa1)
			|=> (mode_q == SEC_PRIV);
	endproperty
	a_priv: assert property (p_priv) // RULE20
		else $error("privileged pair did not take effect");

	property p_no_boot_unl;
		@(posedge clk) disable iff (rst)
		(mode_q == SEC_UNLOCKED) |=> (mode_q != SEC_BOOT);
	endproperty
	a_no_boot_unl: assert property (p_no_boot_unl) // RULE16
		else $error("boot entered from unlocked");

	property p_abort;
		@(posedge clk) disable iff (rst)
		(wr && wdata != unl0 && wdata != fa0) |=> (!arm_unl_q && !arm_fa_q);
	endproperty
	a_abort: assert property (p_abort) // RULE17
		else $error("key sequence survived a foreign write");

	// only a first word from the unarmed state; an armed repeat may be key 1
	sequence s_half_key;
		wr && wdata == unl0 && mode_q == SEC_LOCKED && !arm_unl_q;
	endsequence
	property p_half_no_unlock;
		@(posedge clk) disable iff (rst)
		s_half_key |=> (mode_q == SEC_LOCKED) && arm_unl_q;
	endproperty
	a_half_no_unlock: assert property (p_half_no_unlock) // RULE17
		else $error("first key word alone changed state");

endmodule
`default_nettype wire

// File: rtl/dfba_top.sv
// command space gateway to data flash blocks with security modes
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: 0x00 to select gives general flash mode
// RULE2: 32 block bytes mirrored at 0x40 to 0x5F
// RULE3: single bytes read or written by offset
// RULE4: commit only after correct checksum byte
// RULE5: block index picks 32-byte block of subclass
// RULE6: host sets subclass then block index
// RULE7: data beyond 32-byte block is ignored
// RULE8: written values are never range-checked
// RULE9: committed data survives reset
// RULE10: manufacturer mode: index 1..3 loads A/B/C
// RULE11: manufacturer block committed on valid checksum
// RULE12: block A read-only while locked
// RULE13: 96 bytes, three blocks in subclass 58
// RULE14: unlocked general mode reaches manufacturer blocks too
// RULE15: permissions follow security state
// RULE16: only privileged enters boot or writes keys
// RULE17: two consecutive key words, others abort
// RULE18: keys must differ from subcommand codes
// RULE19: sealed flag set locked, cleared by unlock
// RULE20: full access flag cleared by privileged keys
// RULE21: keys in flash, changed only when privileged
// RULE22: key words written byte-swapped
// RULE23: select 0x01 gives manufacturer block indexing
// RULE24: checksum is 255 minus low sum byte
// RULE25: locked mode gives no general flash access
// RULE26: bad checksum leaves flash and buffer alone
module dfba_top
	import dfba_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	// command space byte port
	input  wire logic [7:0]  CMD_ADDR,
	input  wire logic [7:0]  CMD_WDATA,
	input  wire logic        CMD_WR,
	input  wire logic        CMD_RD,
	output logic      [7:0]  CMD_RDATA,
	output logic             CMD_BUSY,
	// control word port
	input  wire logic        CTL_WR,
	input  wire logic [15:0] CTL_WDATA,
	output logic      [15:0] CTL_STATUS
);

	dfba_sec_t         mode;
	dfba_xfer_t        st_q;
	logic [7:0]        subclass_q;
	logic [7:0]        blkidx_q;
	logic [7:0]        csum_q;
	logic [7:0]        acc_sel_q;
	logic [31:0][7:0]  buf_q;
	logic [OFF_W-1:0]  cnt_q;
	logic [BA_W-1:0]   blk_addr_q;
	logic              blk_valid_q;
	logic [7:0]        rdata_q;
	logic [7:0]        fl_rdata;
	logic [63:0]       key_bytes;

	wire logic locked = (mode == SEC_LOCKED);
	wire logic priv   = (mode == SEC_PRIV);
	wire logic boot   = (mode == SEC_BOOT);

	// host writes are only taken while no block move is running
	wire logic wr_ok = CMD_WR && (st_q == XF_IDLE) && !boot; // RULE15
	wire logic in_win = (CMD_ADDR >= CMD_WIN_BASE)
		&& (CMD_ADDR <= CMD_WIN_LAST);
	wire logic [OFF_W-1:0] win_off = CMD_ADDR[OFF_W-1:0];

	// locked, or select not general, turns index into a block picker
	wire logic mfr_mode = locked || (acc_sel_q != ACC_GENERAL); // RULE23
	wire logic mfr_pick = (CMD_WDATA >= 8'h01) && (CMD_WDATA <= 8'h03);
	wire logic wr_blk   = wr_ok && (CMD_ADDR == CMD_BLKIDX);
	wire logic load_mfr = wr_blk && mfr_mode && mfr_pick; // RULE10
	wire logic load_gen = wr_blk && !mfr_mode; // RULE25
	wire logic [BLK_W-1:0] mfr_blk = CMD_WDATA[BLK_W-1:0] - 2'h1;
	wire logic [BA_W-1:0] load_addr = load_mfr ? {MFR_SC, mfr_blk}
		: {subclass_q[SC_W-1:0], CMD_WDATA[BLK_W-1:0]}; // RULE5

	wire logic wr_csum  = wr_ok && (CMD_ADDR == CMD_CSUM);
	wire logic [7:0] csum_exp = CSUM_BASE - byte_sum(buf_q);
	wire logic csum_good = (CMD_WDATA == csum_exp); // RULE24
	wire logic blk_is_mfr = (blk_addr_q[BA_W-1:BLK_W] == MFR_SC)
		&& (blk_addr_q[BLK_W-1:0] != 2'h3); // RULE13
	wire logic blk_is_a = blk_is_mfr && (blk_addr_q[BLK_W-1:0] == MFR_A_BLK);
	wire logic blk_is_key = (blk_addr_q == KEY_BLK);
	// no range check of the data itself: only the target is vetted
	wire logic commit_ok = blk_valid_q
		&& !(locked && blk_is_a) // RULE12
		&& !(locked && !blk_is_mfr) // RULE15
		&& !(blk_is_key && !priv); // RULE21
	wire logic start_commit = wr_csum && csum_good && commit_ok; // RULE4

	wire logic wr_sc  = wr_ok && (CMD_ADDR == CMD_SUBCLASS) && !locked;
	wire logic wr_acc = wr_ok && (CMD_ADDR == CMD_ACCSEL) && !locked;
	wire logic wr_buf = wr_ok && in_win; // RULE7

	// flash side
	wire logic              fl_we    = (st_q == XF_COMMIT);
	wire logic [FA_W-1:0]   fl_addr  = {blk_addr_q, cnt_q};
	wire logic [7:0]        fl_wdata = buf_q[cnt_q];

	dfba_flash #(
		.AW        (FA_W)
	) u_flash (
		.clk       (CLK_SYS),
		.we        (fl_we),
		.waddr     (fl_addr),
		.wdata     (fl_wdata),
		.raddr     (fl_addr),
		.rdata     (fl_rdata),
		.key_bytes (key_bytes)
	);

	dfba_keyseq u_keys (
		.clk       (CLK_SYS),
		.rst       (RESET),
		.wr        (CTL_WR),
		.wdata     (CTL_WDATA),
		.key_bytes (key_bytes),
		.mode      (mode)
	);

	// block move sequencer
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			st_q  <= XF_IDLE;
			cnt_q <= '0;
		end else begin
			case (st_q)
			XF_IDLE: begin
				cnt_q <= '0;
				if (load_mfr || load_gen) begin
					st_q <= XF_LOAD;
				end else if (start_commit) begin
					st_q <= XF_COMMIT; // RULE11
				end
			end
			XF_LOAD, XF_COMMIT: begin
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == 5'h1F) begin
					st_q <= XF_IDLE;
				end
			end
			default: st_q <= XF_IDLE;
			endcase
		end
	end

	// selection registers
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			subclass_q  <= 8'h00;
			blkidx_q    <= 8'h00;
			acc_sel_q   <= ACC_GENERAL;
			blk_addr_q  <= '0;
			blk_valid_q <= 1'b0;
		end else begin
			if (wr_sc) begin
				subclass_q <= CMD_WDATA; // RULE6
			end
			if (wr_acc) begin
				acc_sel_q <= CMD_WDATA; // RULE1
			end
			if (wr_blk) begin
				blkidx_q <= CMD_WDATA;
			end
			if (load_mfr || load_gen) begin
				blk_addr_q  <= load_addr; // RULE14
				blk_valid_q <= 1'b1;
			end else if (wr_blk || wr_sc || wr_acc) begin
				blk_valid_q <= 1'b0;
			end
		end
	end

	// block buffer; a failed checksum leaves it for correction
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			buf_q  <= '0;
			csum_q <= 8'h00;
		end else begin
			if (st_q == XF_LOAD) begin
				buf_q[cnt_q] <= fl_rdata; // RULE2
			end else if (wr_buf) begin
				buf_q[win_off] <= CMD_WDATA; // RULE3 RULE8
			end
			if (wr_csum) begin
				csum_q <= CMD_WDATA; // RULE26
			end
		end
	end

	// read mux, registered on the read strobe
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		if (boot) begin
			rd_val = 8'h00; // RULE15
		end else if (in_win) begin
			rd_val = buf_q[win_off];
		end else begin
			case (CMD_ADDR)
			CMD_SUBCLASS: rd_val = locked ? 8'h00 : subclass_q;
			CMD_BLKIDX:   rd_val = blkidx_q;
			CMD_CSUM:     rd_val = csum_q;
			CMD_ACCSEL:   rd_val = locked ? 8'h00 : acc_sel_q;
			default:      rd_val = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			rdata_q <= 8'h00;
		end else if (CMD_RD) begin
			rdata_q <= rd_val;
		end
	end

	assign CMD_RDATA = rdata_q;
	assign CMD_BUSY  = (st_q != XF_IDLE);

	always_comb begin
		CTL_STATUS = 16'h0000;
		CTL_STATUS[ST_SEALED_BIT] = locked; // RULE19
		CTL_STATUS[ST_FAS_BIT]    = !priv; // RULE20
		CTL_STATUS[ST_BOOT_BIT]   = boot;
	end

	property p_commit_needs_sum;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(st_q == XF_COMMIT) |-> $past(wr_csum && csum_good);
	endproperty
	a_commit_needs_sum: assert property (p_commit_needs_sum) // RULE4
		else $error("commit without a matching checksum");

	property p_bad_sum;
		@(posedge CLK_SYS) disable iff (RESET)
		(wr_csum && !csum_good) |=> (st_q == XF_IDLE) && $stable(buf_q);
	endproperty
	a_bad_sum: assert property (p_bad_sum) // RULE26
		else $error("bad checksum disturbed flash or buffer");

	property p_mfr_load;
		@(posedge CLK_SYS) disable iff (RESET)
		load_mfr |=> (st_q == XF_LOAD)
			&& (blk_addr_q[BA_W-1:BLK_W] == MFR_SC)
			&& (blk_addr_q[BLK_W-1:0] == $past(mfr_blk));
	endproperty
	a_mfr_load: assert property (p_mfr_load) // RULE10
		else $error("manufacturer block not selected");

	sequence s_load_start;
		(st_q == XF_IDLE) && (load_mfr || load_gen);
	endsequence
	sequence s_load_end;
		(st_q == XF_LOAD) && (cnt_q == 5'h1F) ##1 (st_q == XF_IDLE);
	endsequence
	property p_load_len;
		@(posedge CLK_SYS) disable iff (RESET)
		s_load_start |=> (st_q == XF_LOAD) && (cnt_q == 5'h00) ##31 s_load_end;
	endproperty
	a_load_len: assert property (p_load_len) // RULE2
		else $error("block load did not take 32 cycles");

	property p_a_locked;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(st_q == XF_COMMIT) |-> !($past(locked) && blk_is_a);
	endproperty
	a_a_locked: assert property (p_a_locked) // RULE12
		else $error("block A written while locked");

	property p_boot_no_access;
		@(posedge CLK_SYS) disable iff (RESET)
		(boot && st_q == XF_IDLE) |=> (st_q == XF_IDLE);
	endproperty
	a_boot_no_access: assert property (p_boot_no_access) // RULE15
		else $error("flash moved in boot mode");

	property p_key_priv;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(st_q == XF_COMMIT) && blk_is_key |-> $past(priv);
	endproperty
	a_key_priv: assert property (p_key_priv) // RULE21
		else $error("key block written outside privileged mode");

	property p_locked_no_gen;
		@(posedge CLK_SYS) disable iff (RESET)
		(locked && wr_blk && !mfr_pick) |=> (st_q == XF_IDLE);
	endproperty
	a_locked_no_gen: assert property (p_locked_no_gen) // RULE25
		else $error("locked mode reached general flash");

	property p_we_only_commit;
		@(posedge CLK_SYS) disable iff (RESET)
		$rose(st_q == XF_COMMIT) |-> (fl_we && cnt_q == 5'h00)
			##31 (fl_we && cnt_q == 5'h1F) ##1 !fl_we;
	endproperty
	a_we_only_commit: assert property (p_we_only_commit) // RULE11
		else $error("commit write sequence broken");

endmodule
`default_nettype wire

// File: testbench/dfba_host.sv
// host controller model driving the command and control ports
`timescale 1ns/1ps
`default_nettype none
module dfba_host (
	// clock
	input  wire logic        clk,
	// command port
	output logic      [7:0]  cmd_addr,
	output logic      [7:0]  cmd_wdata,
	output logic             cmd_wr,
	output logic             cmd_rd,
	input  wire logic [7:0]  cmd_rdata,
	input  wire logic        cmd_busy,
	// control port
	output logic             ctl_wr,
	output logic      [15:0] ctl_wdata
);
	logic [7:0] shadow [32];
	int         busy_n;

	initial begin
		cmd_addr = 8'h00;
		cmd_wdata = 8'h00;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		ctl_wr = 1'b0;
		ctl_wdata = 16'h0000;
		busy_n = 0;
	end

	// one byte write; counts the busy span it starts, bounded in case of hang
	task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
		cmd_addr <= ~a;
		cmd_wdata <= ~d;
		busy_n = 0;
		#1;
		while (cmd_busy === 1'b1 && busy_n < 40) begin
			@(posedge clk);
			busy_n++;
			#1;
		end
		if (a >= 8'h40 && a <= 8'h5F)
			shadow[a[4:0]] = d;
	endtask

	// read data is registered, so it is taken just after the sampling edge
	task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk);
		cmd_rd <= 1'b0;
		cmd_addr <= ~a;
		#1;
		d = cmd_rdata;
	endtask

	// mirror the window so a checksum can cover bytes never edited
	task automatic pull;
		for (int i = 0; i < 32; i++)
			rd_b(8'h40 + 8'(i), shadow[i]);
	endtask

	// bad flips the low bit so the block must be refused
	task automatic send_sum(input logic bad);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 32; i++)
			s = s + shadow[i];
		wr_b(8'h60, (8'hFF - s) ^ {7'h00, bad});
	endtask

	task automatic ctl(input logic [15:0] w);
		@(posedge clk);
		ctl_wdata <= w;
		ctl_wr <= 1'b1;
		@(posedge clk);
		ctl_wr <= 1'b0;
		ctl_wdata <= ~w;
		#1;
	endtask

	// keys are given as stored; each word goes out with its bytes swapped
	task automatic keys(input logic [15:0] k0, input logic [15:0] k1);
		ctl({k0[7:0], k0[15:8]});
		ctl({k1[7:0], k1[15:8]});
	endtask
endmodule
`default_nettype wire

// File: testbench/dfba_top_tb.sv
// self-checking bench of the data flash block access gateway
`timescale 1ns/1ps
`default_nettype none
module dfba_top_tb
	import dfba_pkg::*;
;
	logic             clk;
	logic             rst;
	wire logic [7:0]  cmd_addr;
	wire logic [7:0]  cmd_wdata;
	wire logic        cmd_wr;
	wire logic        cmd_rd;
	wire logic [7:0]  cmd_rdata;
	wire logic        cmd_busy;
	wire logic        ctl_wr;
	wire logic [15:0] ctl_wdata;
	wire logic [15:0] ctl_status;
	int               error_cnt = 0;
	int               n_compared = 0;

	dfba_top DUT (.CLK_SYS(clk), .RESET(rst), .CMD_ADDR(cmd_addr),
		.CMD_WDATA(cmd_wdata), .CMD_WR(cmd_wr), .CMD_RD(cmd_rd),
		.CMD_RDATA(cmd_rdata), .CMD_BUSY(cmd_busy), .CTL_WR(ctl_wr),
		.CTL_WDATA(ctl_wdata), .CTL_STATUS(ctl_status));

	dfba_host h (.clk(clk), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.cmd_busy(cmd_busy), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [7:0] exp);
		logic [7:0] d;
		h.rd_b(a, d);
		chk(nm, {8'h00, d}, {8'h00, exp});
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
	endtask

	// general mode selection: mode, subclass, then block index
	task automatic gen_load(input logic [7:0] sc, input logic [7:0] blk);
		h.wr_b(CMD_ACCSEL, ACC_GENERAL);
		h.wr_b(CMD_SUBCLASS, sc);
		h.wr_b(CMD_BLKIDX, blk);
	endtask

	task automatic t_locked;
		chk("status", ctl_status, 16'h6000);
		h.wr_b(CMD_SUBCLASS, 8'h50);
		rdc("subclass", CMD_SUBCLASS, 8'h00);
		h.wr_b(CMD_ACCSEL, 8'h00);
		rdc("select", CMD_ACCSEL, 8'h00);
		h.wr_b(CMD_BLKIDX, 8'h01);
		chk("load span", 16'(h.busy_n), 16'(BLK_BYTES));
		rdc("block A", 8'h45, 8'hFF);
		h.pull();
		h.wr_b(8'h45, 8'h11);
		h.send_sum(1'b0);
		chk("A commit", 16'(h.busy_n), 16'h0000);
		h.wr_b(CMD_BLKIDX, 8'h01);
		rdc("A kept", 8'h45, 8'hFF);
		h.wr_b(CMD_BLKIDX, 8'h02);
		for (int i = 0; i < 32; i++)
			h.wr_b(CMD_WIN_BASE + 8'(i), 8'hA0 + 8'(i));
		h.wr_b(8'h62, 8'h55);
		rdc("beyond window", 8'h62, 8'h00);
		h.send_sum(1'b1);
		chk("bad sum", 16'(h.busy_n), 16'h0000);
		rdc("buffer kept", 8'h5F, 8'hBF);
		rdc("sum byte", CMD_CSUM, 8'h0E);
		rdc("index", CMD_BLKIDX, 8'h02);
		h.send_sum(1'b0);
		chk("commit span", 16'(h.busy_n), 16'(BLK_BYTES));
		h.wr_b(CMD_BLKIDX, 8'h03);
		rdc("block C", CMD_WIN_BASE, 8'hFF);
		h.wr_b(CMD_BLKIDX, 8'h02);
		rdc("block B", 8'h47, 8'hA7);
	endtask

	task automatic t_unlock;
		h.ctl(16'hFFFF);
		h.ctl(16'h0000);
		h.ctl(16'hFFFF);
		chk("aborted", ctl_status, 16'h6000);
		h.ctl(16'h0000);
		h.keys(16'hFFFF, 16'hFFFF);
		chk("unlocked", ctl_status, 16'h4000);
		h.ctl(SUB_BOOT);
		chk("boot refused", ctl_status, 16'h4000);
	endtask

	task automatic t_general;
		gen_load({1'b0, MFR_SC}, 8'h01);
		rdc("B via general", 8'h47, 8'hA7);
		gen_load(8'h50, 8'h01);
		h.pull();
		h.wr_b(8'h40 + 8'(48 % 32), 8'h3C);
		h.send_sum(1'b0);
		chk("general commit", 16'(h.busy_n), 16'(BLK_BYTES));
		h.wr_b(CMD_ACCSEL, ACC_MFR);
		h.wr_b(CMD_BLKIDX, 8'h02);
		rdc("mfr indexing", 8'h47, 8'hA7);
		do_reset();
		chk("relocked", ctl_status, 16'h6000);
		h.keys(16'hFFFF, 16'hFFFF);
		gen_load(8'h50, 8'h01);
		rdc("persisted", 8'h50, 8'h3C);
	endtask

	// new keys differ from every subcommand code
	task automatic t_priv;
		h.keys(16'hFFFF, 16'hFFFF);
		chk("privileged", ctl_status, 16'h0000);
		gen_load(8'h70, 8'h00);
		h.pull();
		h.wr_b(8'h40, 8'h12);
		h.wr_b(8'h41, 8'h34);
		h.wr_b(8'h42, 8'h56);
		h.wr_b(8'h43, 8'h78);
		h.send_sum(1'b0);
		chk("key commit", 16'(h.busy_n), 16'(BLK_BYTES));
		h.ctl(SUB_SEAL);
		chk("sealed", ctl_status, 16'h6000);
		h.ctl(16'h1234);
		h.ctl(16'h5678);
		chk("unswapped", ctl_status, 16'h6000);
		h.ctl(16'h0000);
		h.keys(16'h1234, 16'h5678);
		chk("new keys", ctl_status, 16'h4000);
		h.keys(16'hFFFF, 16'hFFFF);
		h.ctl(SUB_BOOT);
		chk("boot", ctl_status, 16'hC000);
		rdc("boot read", 8'h50, 8'h00);
		h.ctl(SUB_EXIT_BOOT);
		chk("boot exit", ctl_status, 16'h6000);
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("idle busy", {15'h0000, cmd_busy}, 16'h0000);
		t_locked();
		t_unlock();
		t_general();
		t_priv();
		give_verdict();
	end
endmodule
`default_nettype wire
